//--- hdl/odt_pd_pkg.sv
package odt_pd_pkg;

  // Core clock: 200 MHz
  localparam int CLK_PERIOD_PS   = 5000;

  // Asynchronous termination delays, printed in ns, held here in ps
  localparam int T_AONPD_MIN_PS  = 2000;
  localparam int T_AONPD_MAX_PS  = 8500;
  localparam int T_AOFPD_MIN_PS  = 2000;
  localparam int T_AOFPD_MAX_PS  = 8500;

  // Least times round up, longest times round down, never below one cycle
  localparam int AONPD_MIN_CYC_R = (T_AONPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AONPD_MAX_CYC_R = T_AONPD_MAX_PS / CLK_PERIOD_PS;
  localparam int AOFPD_MIN_CYC_R = (T_AOFPD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AOFPD_MAX_CYC_R = T_AOFPD_MAX_PS / CLK_PERIOD_PS;
  localparam int AONPD_MIN_CYC   = (AONPD_MIN_CYC_R < 1) ? 1 : AONPD_MIN_CYC_R;
  localparam int AONPD_MAX_CYC   = (AONPD_MAX_CYC_R < 1) ? 1 : AONPD_MAX_CYC_R;
  localparam int AOFPD_MIN_CYC   = (AOFPD_MIN_CYC_R < 1) ? 1 : AOFPD_MIN_CYC_R;
  localparam int AOFPD_MAX_CYC   = (AOFPD_MAX_CYC_R < 1) ? 1 : AOFPD_MAX_CYC_R;

  // Asynchronous path latency in cycles after ODT is sampled
  localparam int ASYNC_CYC       = (AONPD_MIN_CYC > AOFPD_MIN_CYC) ? AONPD_MIN_CYC
                                                                   : AOFPD_MIN_CYC;

  // Latency offsets against write latency
  localparam int ODTL_WL_SUB     = 2;  // turn-on / turn-off latency = WL - 2
  localparam int ANPD_ENTRY_SUB  = 1;  // entry lead = WL - 1
  localparam int WL_MIN          = 4;

  // Plain defaults for timings that the block takes as parameters
  localparam int MAX_WL_DEF      = 24;
  localparam int T_CPDED_CYC_DEF = 1;
  localparam int T_RFC_CYC_DEF   = 22;
  localparam int T_XPDLL_CYC_DEF = 10;

  localparam int LAT_W           = 5;

  // History lanes
  localparam int H_ODT           = 0;
  localparam int H_FALL          = 1;
  localparam int H_RISE          = 2;
  localparam int H_ENT_POST      = 3;
  localparam int H_EXT_POST      = 4;
  localparam int H_WIDTH         = 5;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_PD
  } pd_state_t;

endpackage : odt_pd_pkg

//--- hdl/pin_sync.sv
`timescale 1ns/10ps

module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // A change counts once the second and third stages agree
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_comb begin
        next_level[b] = (stage2[b] == stage3[b]) ? stage3[b] : level[b];
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign level_o = level;

endmodule : pin_sync

//--- hdl/bit_history.sv
`timescale 1ns/10ps

module bit_history #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 24
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  // Sample in, aged samples out; entry k is k+1 cycles old
  input  wire logic [WIDTH-1:0]            d_i,
  output logic      [DEPTH-1:0][WIDTH-1:0] hist_o
);

  initial begin
    if (WIDTH < 1 || DEPTH < 2) $error("bit_history: WIDTH >= 1 and DEPTH >= 2 required");
  end

  logic [DEPTH-1:0][WIDTH-1:0] hist;
  logic [DEPTH-1:0][WIDTH-1:0] next_hist;

  always_comb begin
    next_hist = {hist[DEPTH-2:0], d_i};
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hist <= '0;
    end else begin
      hist <= next_hist;
    end
  end

  assign hist_o = hist;

endmodule : bit_history

//--- hdl/odt_pd_transition.sv
// How it works
// [R1] Frozen-DLL power-down: termination turns on 2 to 8.5 ns after ODT sampled high.
// [R2] Frozen-DLL power-down: termination turns off 2 to 8.5 ns after ODT sampled low.
// [R3] DLL frozen in power-down gives an entry window allowing either response.
// [R4] Entry window: opens lead clocks before CKE low, closes after command-pass-disable delay.
// [R5] Entry lead equals write latency minus one, counted back from CKE low.
// [R6] Running refresh: entry window closes at later of refresh time or disable delay.
// [R7] Entry window start clock excluded, its closing point included.
// [R8] ODT raised in entry window changes termination within sync/async bound union.
// [R9] ODT lowered in entry window changes termination no later than larger maximum.
// [R10] Exit window opens lead before CKE high, closes DLL exit delay after.
// [R11] Exit lead equals larger of turn-on and turn-off latencies.
// [R12] ODT raised in exit window changes termination within sync/async bound union.
// [R13] ODT lowered in exit window changes termination within sync/async bound union.
// [R14] Overlapping entry then exit windows: either response from entry start to exit end.
// [R15] Overlapping exit then entry windows: either response from exit start to entry end.
// [R16] Before entry and after exit windows synchronous; between them asynchronous.
// [R17] Asynchronous mode ignores additive latency on the ODT input.
// [R18] Controller tracks windows and treats termination as uncertain inside them.
`timescale 1ns/10ps

module odt_pd_transition #(
  parameter int MAX_WL      = odt_pd_pkg::MAX_WL_DEF,
  parameter int T_CPDED_CYC = odt_pd_pkg::T_CPDED_CYC_DEF,
  parameter int T_RFC_CYC   = odt_pd_pkg::T_RFC_CYC_DEF,
  parameter int T_XPDLL_CYC = odt_pd_pkg::T_XPDLL_CYC_DEF
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  // Pins from the controller
  input  wire logic                         cke_pin_i,
  input  wire logic                         odt_pin_i,
  // Command decoder and mode register
  input  wire logic                         refresh_i,
  input  wire logic                         dll_frozen_i,
  input  wire logic [odt_pd_pkg::LAT_W-1:0] cwl_i,
  input  wire logic [odt_pd_pkg::LAT_W-1:0] al_i,
  // Termination control
  output logic                              rtt_on_o,
  output logic                              async_mode_o,
  output logic                              pd_active_o,
  // Window report, MAX_WL cycles behind the live timeline
  output logic                              entry_win_o,
  output logic                              exit_win_o
);

  localparam int LOOK = MAX_WL;
  localparam int CW   = 8;
  localparam logic [CW-1:0] CPDED_C = CW'(T_CPDED_CYC);
  localparam logic [CW-1:0] RFC_C   = CW'(T_RFC_CYC - 1);
  localparam logic [CW-1:0] XPDLL_C = CW'(T_XPDLL_CYC);
  localparam logic [5:0]    WL_MAX  = 6'(MAX_WL);
  localparam logic [5:0]    WL_LOW  = 6'(odt_pd_pkg::WL_MIN);
  localparam int CPDED_A = T_CPDED_CYC;
  localparam int XPDLL_A = T_XPDLL_CYC;

  initial begin
    if (MAX_WL < odt_pd_pkg::WL_MIN || MAX_WL > 62)
      $error("odt_pd_transition: MAX_WL out of range");
    if (T_CPDED_CYC < 1 || T_CPDED_CYC > 255) $error("odt_pd_transition: bad T_CPDED_CYC");
    if (T_RFC_CYC < 2 || T_RFC_CYC > 255) $error("odt_pd_transition: bad T_RFC_CYC");
    if (T_XPDLL_CYC < 1 || T_XPDLL_CYC > 255) $error("odt_pd_transition: bad T_XPDLL_CYC");
    if (odt_pd_pkg::ASYNC_CYC > odt_pd_pkg::AONPD_MAX_CYC ||
        odt_pd_pkg::ASYNC_CYC > odt_pd_pkg::AOFPD_MAX_CYC)
      $error("odt_pd_transition: async delay cannot meet both bounds at this clock");
  end

  // Pin synchronisers
  logic [1:0] pins_s;
  logic       cke_s;
  logic       odt_s;

  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({cke_pin_i, odt_pin_i}),
    .level_o   (pins_s)
  );

  assign cke_s = pins_s[1];
  assign odt_s = pins_s[0];

  // Latencies; additive latency reaches the synchronous path and the window leads, not the async path
  logic [5:0] wl_raw;
  logic [5:0] wl;
  logic [5:0] odtl;
  logic [5:0] ent_lead;
  logic [5:0] ext_lead;

  always_comb begin
    wl_raw = 6'(cwl_i) + 6'(al_i);
    if (wl_raw > WL_MAX) begin
      wl = WL_MAX;
    end else if (wl_raw < WL_LOW) begin
      wl = WL_LOW;
    end else begin
      wl = wl_raw;
    end
    odtl     = wl - 6'(odt_pd_pkg::ODTL_WL_SUB);
    ent_lead = wl - 6'(odt_pd_pkg::ANPD_ENTRY_SUB); // see [R5]
    ext_lead = odtl;                                // see [R11]
  end

  // Power-down tracking
  odt_pd_pkg::pd_state_t state;
  odt_pd_pkg::pd_state_t next_state;
  logic                  fall;
  logic                  rise;

  always_comb begin
    next_state = state;
    fall       = 1'b0;
    rise       = 1'b0;
    unique case (state)
      odt_pd_pkg::ST_BOOT: begin
        if (cke_s) next_state = odt_pd_pkg::ST_IDLE;
      end
      odt_pd_pkg::ST_IDLE: begin
        if (!cke_s) begin
          next_state = odt_pd_pkg::ST_PD;
          fall       = dll_frozen_i; // see [R3]
        end
      end
      odt_pd_pkg::ST_PD: begin
        if (cke_s) begin
          next_state = odt_pd_pkg::ST_IDLE;
          rise       = dll_frozen_i;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= odt_pd_pkg::ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // Refresh, entry and exit counters
  logic [CW-1:0] rfc_cnt;
  logic [CW-1:0] ent_cnt;
  logic [CW-1:0] ext_cnt;
  logic [CW-1:0] next_rfc_cnt;
  logic [CW-1:0] next_ent_cnt;
  logic [CW-1:0] next_ext_cnt;
  logic          ent_post;
  logic          ext_post;

  always_comb begin
    next_rfc_cnt = (rfc_cnt != '0) ? rfc_cnt - CW'(1) : '0;
    if (refresh_i) next_rfc_cnt = RFC_C;
    next_ent_cnt = (ent_cnt != '0) ? ent_cnt - CW'(1) : '0;
    if (fall) begin
      // Later of refresh end and disable delay, end point included
      next_ent_cnt = (rfc_cnt > CPDED_C) ? rfc_cnt : CPDED_C; // see [R4] see [R6] see [R7]
    end
    next_ext_cnt = (ext_cnt != '0) ? ext_cnt - CW'(1) : '0;
    if (rise) next_ext_cnt = XPDLL_C; // see [R10]
    ent_post = fall || (ent_cnt != '0);
    ext_post = rise || (ext_cnt != '0);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rfc_cnt <= '0;
      ent_cnt <= '0;
      ext_cnt <= '0;
    end else begin
      rfc_cnt <= next_rfc_cnt;
      ent_cnt <= next_ent_cnt;
      ext_cnt <= next_ext_cnt;
    end
  end

  // Timeline history for the synchronous path and the window report
  logic [LOOK-1:0][odt_pd_pkg::H_WIDTH-1:0] hist;
  logic [odt_pd_pkg::H_WIDTH-1:0]           hist_d;

  always_comb begin
    hist_d                         = '0;
    hist_d[odt_pd_pkg::H_ODT]      = odt_s;
    hist_d[odt_pd_pkg::H_FALL]     = fall;
    hist_d[odt_pd_pkg::H_RISE]     = rise;
    hist_d[odt_pd_pkg::H_ENT_POST] = ent_post;
    hist_d[odt_pd_pkg::H_EXT_POST] = ext_post;
  end

  bit_history #(
    .WIDTH (odt_pd_pkg::H_WIDTH),
    .DEPTH (LOOK)
  ) u_history (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (hist_d),
    .hist_o    (hist)
  );

  // Leading part of a window: the event lies within lead cycles after the reported cycle
  logic [LOOK-1:0] ent_hit;
  logic [LOOK-1:0] ext_hit;

  genvar k;
  generate
    for (k = 0; k < LOOK; k++) begin : g_lead
      // Start clock itself falls outside the window
      assign ent_hit[k] = hist[k][odt_pd_pkg::H_FALL] &&
                          (6'(k) >= 6'(LOOK) - ent_lead); // see [R4] see [R7]
      assign ext_hit[k] = hist[k][odt_pd_pkg::H_RISE] &&
                          (6'(k) >= 6'(LOOK) - ext_lead); // see [R10]
    end
  endgenerate

  // Synchronous tap: ODT as sampled odtl cycles before the output edge
  function automatic logic odt_at_age(input logic [5:0] age);
    logic r;
    r = odt_s;
    for (int i = 1; i <= LOOK; i++) begin
      if (6'(i) == age) r = hist[i-1][odt_pd_pkg::H_ODT];
    end
    return r;
  endfunction

  // Termination control
  logic mode_async;
  logic sync_tap;
  logic rtt_on;
  logic async_mode;
  logic entry_win;
  logic exit_win;
  logic next_rtt_on;
  logic next_async_mode;
  logic next_entry_win;
  logic next_exit_win;

  always_comb begin
    // Async from CKE low to CKE high while the DLL is frozen; both edges lie inside a window
    mode_async      = (state == odt_pd_pkg::ST_PD) && dll_frozen_i; // see [R16]
    next_async_mode = mode_async;
    sync_tap        = odt_at_age(odtl - 6'(1));
    // Inside windows either path may act; the switch keeps both bounds
    if (mode_async) begin
      // Additive latency bypassed, fixed delay from the sampled level
      next_rtt_on = odt_at_age(6'(odt_pd_pkg::ASYNC_CYC - 1)); // see [R1] see [R2] see [R17]
    end else begin
      next_rtt_on = sync_tap; // see [R16] see [R8] see [R9] see [R12] see [R13]
    end
    // Union of windows spans overlaps in either order
    next_entry_win = (|ent_hit) || hist[LOOK-1][odt_pd_pkg::H_ENT_POST]; // see [R14]
    next_exit_win  = (|ext_hit) || hist[LOOK-1][odt_pd_pkg::H_EXT_POST]; // see [R15]
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rtt_on     <= 1'b0;
      async_mode <= 1'b0;
      entry_win  <= 1'b0;
      exit_win   <= 1'b0;
    end else begin
      rtt_on     <= next_rtt_on;
      async_mode <= next_async_mode;
      entry_win  <= next_entry_win;
      exit_win   <= next_exit_win;
    end
  end

  assign rtt_on_o     = rtt_on;
  assign async_mode_o = async_mode;
  assign pd_active_o  = (state == odt_pd_pkg::ST_PD);
  assign entry_win_o  = entry_win;
  assign exit_win_o   = exit_win;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_async_turn_on: assert property (mode_async && odt_s |=> rtt_on_o) // see [R1]
    else $error("async turn-on missed its one-cycle slot");

  a_async_turn_off: assert property (mode_async && !odt_s |=> !rtt_on_o) // see [R2]
    else $error("async turn-off missed its one-cycle slot");

  a_async_no_al: assert property ( // see [R17]
    mode_async && $changed(odt_s) && (al_i != '0) |=> (rtt_on_o == $past(odt_s)))
    else $error("async path delayed by additive latency");

  a_dll_on_sync: assert property (!dll_frozen_i |=> !async_mode_o) // see [R3]
    else $error("async mode without frozen DLL");

  a_entry_close: assert property ( // see [R4]
    fall && (rfc_cnt <= CPDED_C) |-> ##1 (ent_cnt == CPDED_C) ##CPDED_A !ent_post)
    else $error("entry window length wrong");

  a_refresh_close: assert property ( // see [R6]
    fall && (rfc_cnt > CPDED_C) |=> (ent_cnt == $past(rfc_cnt)))
    else $error("entry window ignores running refresh");

  a_exit_close: assert property ( // see [R10]
    rise |-> ext_post ##XPDLL_A ext_post ##1 !ext_post)
    else $error("exit window length wrong");

  a_entry_lead: assert property ( // see [R5]
    hist[LOOK-1][odt_pd_pkg::H_FALL] |=> entry_win_o)
    else $error("entry window missing at CKE low cycle");

  a_sync_outside: assert property ( // see [R16]
    (state == odt_pd_pkg::ST_IDLE) && $stable(odtl) && $stable(state)
    |=> (rtt_on_o == $past(sync_tap)))
    else $error("sync path latency wrong");

  a_exit_lead: assert property ( // see [R11]
    hist[LOOK-1][odt_pd_pkg::H_RISE] |=> exit_win_o)
    else $error("exit window missing at CKE high cycle");

  a_entry_tail: assert property ( // see [R14]
    hist[LOOK-1][odt_pd_pkg::H_ENT_POST] |=> entry_win_o)
    else $error("entry window tail not reported");

  a_exit_tail: assert property ( // see [R15]
    hist[LOOK-1][odt_pd_pkg::H_EXT_POST] |=> exit_win_o)
    else $error("exit window tail not reported");

  a_refresh_load: assert property (refresh_i |=> (rfc_cnt == RFC_C)) // see [R6]
    else $error("refresh timer not loaded");

  a_exit_load: assert property (rise |=> (ext_cnt == XPDLL_C)) // see [R10]
    else $error("exit timer not loaded");

  a_frozen_edges: assert property ((fall || rise) |-> dll_frozen_i) // see [R3]
    else $error("window event without frozen DLL");

  a_idle_sync: assert property ((state == odt_pd_pkg::ST_IDLE) |=> !async_mode_o) // see [R16]
    else $error("async mode outside power-down");

  a_pd_async: assert property ( // see [R16]
    (state == odt_pd_pkg::ST_PD) && dll_frozen_i |=> async_mode_o)
    else $error("sync mode in frozen power-down");

endmodule : odt_pd_transition

//--- test/ddr_ctrl_model.sv
`timescale 1ns/10ps

module ddr_ctrl_model #(
  parameter int SETTLE_CYC = 32
) (
  // Clock
  input  wire logic clk_i,
  // Controller pins and command
  output logic      cke_pin_o,
  output logic      odt_pin_o,
  output logic      refresh_o
);
  initial begin
    cke_pin_o = 1'b1;
    odt_pin_o = 1'b0;
    refresh_o = 1'b0;
  end

  // Refresh command lasts one cycle
  always @(posedge clk_i) begin
    if (refresh_o) begin
      refresh_o <= 1'b0;
    end
  end

  task automatic drive(input logic cke, input logic odt, input logic rfsh);
    @(posedge clk_i);
    cke_pin_o <= cke;
    odt_pin_o <= odt;
    if (rfsh) begin
      refresh_o <= 1'b1;
    end
  endtask : drive

  // Termination timing is uncertain inside the windows, so wait them out
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge clk_i);
  endtask : settle
endmodule : ddr_ctrl_model

//--- test/odt_pd_transition_tb.sv
`timescale 1ns/10ps

module odt_pd_transition_tb;
  localparam int MAX_WL  = 8;
  localparam int T_RFC   = 8;
  localparam int T_XP    = 3;
  localparam int PIN_DLY = 4;

  logic                           clk_i;
  logic                           sys_rst_i;
  logic                           cke_pin;
  logic                           odt_pin;
  logic                           refresh;
  logic                           dll_frozen_i;
  logic [odt_pd_pkg::LAT_W-1:0]   cwl_i;
  logic [odt_pd_pkg::LAT_W-1:0]   al_i;
  logic                           rtt_on_o;
  logic                           async_mode_o;
  logic                           pd_active_o;
  logic                           entry_win_o;
  logic                           exit_win_o;
  int                             n_errors;
  int                             checks;
  int                             n_ent;
  int                             n_ext;
  int                             n_any;
  int                             wl;

  odt_pd_transition #(.MAX_WL(MAX_WL), .T_RFC_CYC(T_RFC), .T_XPDLL_CYC(T_XP))
  u_odt_pd_transition (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cke_pin_i(cke_pin), .odt_pin_i(odt_pin),
    .refresh_i(refresh), .dll_frozen_i(dll_frozen_i), .cwl_i(cwl_i), .al_i(al_i),
    .rtt_on_o(rtt_on_o), .async_mode_o(async_mode_o), .pd_active_o(pd_active_o),
    .entry_win_o(entry_win_o), .exit_win_o(exit_win_o)
  );

  ddr_ctrl_model u_ddr_ctrl_model (
    .clk_i(clk_i), .cke_pin_o(cke_pin), .odt_pin_o(odt_pin), .refresh_o(refresh)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    n_ent = n_ent + int'(entry_win_o === 1'b1);
    n_ext = n_ext + int'(exit_win_o === 1'b1);
    n_any = n_any + int'((entry_win_o | exit_win_o) === 1'b1);
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp_range(input string what, input int seen, input int lo, input int hi);
    checks++;
    if (seen < lo || seen > hi) begin
      n_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : cmp_range

  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp_bit

  // Drive both pins at one edge, count edges until termination follows ODT
  task automatic step(input logic cke, input logic odt, input int lo, input int hi,
                      input string what);
    int n;
    n = 0;
    u_ddr_ctrl_model.drive(cke, odt, 1'b0);
    while (rtt_on_o !== odt && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    cmp_range(what, n, lo, hi);
  endtask : step

  task automatic clear_counts();
    @(negedge clk_i);
    n_ent = 0;
    n_ext = 0;
    n_any = 0;
  endtask : clear_counts

  task automatic t_sync();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      cwl_i <= 5'(5 + i);
      al_i  <= 5'(3 - 3 * i);
      wl = 8 - 2 * i;
      u_ddr_ctrl_model.settle();
      step(1'b1, 1'b1, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "sync on");
      step(1'b1, 1'b0, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "sync off");
    end
  endtask : t_sync

  task automatic t_async();
    @(posedge clk_i);
    dll_frozen_i <= 1'b1;
    cwl_i        <= 5'h05;
    al_i         <= 5'h03;
    wl = 8;
    u_ddr_ctrl_model.drive(1'b0, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    cmp_bit("pd_active_o", 1'b1, pd_active_o);
    cmp_bit("async_mode_o", 1'b1, async_mode_o);
    // Additive latency set: the sync path would answer far later
    step(1'b0, 1'b1, PIN_DLY, PIN_DLY + 2, "async on");
    step(1'b0, 1'b0, PIN_DLY, PIN_DLY + 2, "async off");
    u_ddr_ctrl_model.drive(1'b1, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    cmp_bit("async_mode_o", 1'b0, async_mode_o);
    step(1'b1, 1'b1, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "resync on");
    step(1'b1, 1'b0, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "resync off");
  endtask : t_async

  task automatic t_dll_on();
    @(posedge clk_i);
    dll_frozen_i <= 1'b0;
    clear_counts();
    u_ddr_ctrl_model.drive(1'b0, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    cmp_bit("async_mode_o", 1'b0, async_mode_o);
    step(1'b0, 1'b1, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "pd sync on");
    step(1'b0, 1'b0, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "pd sync off");
    u_ddr_ctrl_model.drive(1'b1, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    cmp_range("windows without freeze", n_any, 0, 0);
    @(posedge clk_i);
    dll_frozen_i <= 1'b1;
    u_ddr_ctrl_model.settle();
  endtask : t_dll_on

  task automatic t_windows();
    clear_counts();
    step(1'b0, 1'b1, PIN_DLY, PIN_DLY + wl - 1, "entry on");
    u_ddr_ctrl_model.settle();
    step(1'b1, 1'b0, PIN_DLY, PIN_DLY + wl - 1, "exit off");
    u_ddr_ctrl_model.settle();
    cmp_range("entry length", n_ent, wl, wl);
    cmp_range("exit length", n_ext, wl - 2 + T_XP, wl - 2 + T_XP);
    step(1'b1, 1'b1, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "pre on");
    u_ddr_ctrl_model.settle();
    step(1'b0, 1'b0, PIN_DLY, PIN_DLY + wl - 1, "entry off");
    u_ddr_ctrl_model.settle();
    step(1'b1, 1'b1, PIN_DLY, PIN_DLY + wl - 1, "exit on");
    u_ddr_ctrl_model.settle();
    step(1'b1, 1'b0, PIN_DLY + wl - 3, PIN_DLY + wl - 1, "post off");
  endtask : t_windows

  task automatic t_refresh();
    int exp;
    exp = wl - 1 + (1 + T_RFC - PIN_DLY);
    u_ddr_ctrl_model.settle();
    clear_counts();
    u_ddr_ctrl_model.drive(1'b0, 1'b0, 1'b1);
    u_ddr_ctrl_model.settle();
    u_ddr_ctrl_model.drive(1'b1, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    cmp_range("entry with refresh", n_ent, exp - 1, exp + 1);
  endtask : t_refresh

  task automatic t_short();
    clear_counts();
    u_ddr_ctrl_model.drive(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk_i);
    u_ddr_ctrl_model.drive(1'b1, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    cmp_range("short pd union", n_any, 3 + T_XP + wl - 3, 3 + T_XP + wl - 1);
    u_ddr_ctrl_model.drive(1'b0, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    clear_counts();
    u_ddr_ctrl_model.drive(1'b1, 1'b0, 1'b0);
    repeat (2) @(posedge clk_i);
    u_ddr_ctrl_model.drive(1'b0, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
    cmp_range("short idle union", n_any, 3 + wl - 2, 3 + wl);
    u_ddr_ctrl_model.drive(1'b1, 1'b0, 1'b0);
    u_ddr_ctrl_model.settle();
  endtask : t_short

  initial begin
    n_errors = 0;
    checks = 0;
    wl = 8;
    sys_rst_i = 1'b1;
    dll_frozen_i = 1'b1;
    cwl_i = 5'h05;
    al_i = 5'h03;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    u_ddr_ctrl_model.settle();
    t_sync();
    t_async();
    t_dll_on();
    t_windows();
    t_refresh();
    t_short();
    end_of_test();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    n_errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule : odt_pd_transition_tb
